// *** core/pdc_config_regs.sv ***
`timescale 1ns/1ns
// Operation
// - float bit high tri-states output two
// - predivide bit inserts divide-by-four reference divider
// - twelve-bit divisor from nibble plus byte
// - divisor resets to 0x032
// - numerator is 22 bits, resets zero
// - denominator is 22 bits, resets zero
// - dither code 0 weak, 3 off
// - order code 0 integer, 3 third-order
// - doubler bit enables reference doubler, resets on
// - pump code 4 is 1.6mA, 8 is 6.4mA
module pdc_config_regs (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic out2_src,
	output logic out2_level,
	output logic out2_oe,
	output logic ref_predivide_sel,
	output logic ref_doubler_en,
	output logic [11:0] loop_integer_divisor,
	output logic [21:0] frac_numerator,
	output logic [21:0] frac_denominator,
	output logic [1:0] dither_select,
	output logic dither_weak,
	output logic dither_off,
	output logic [1:0] modulator_order,
	output logic order_integer,
	output logic order_third,
	output logic [3:0] pump_current_code,
	output logic pump_1p6_ma,
	output logic pump_6p4_ma
);

	typedef struct packed {
		logic [10:0][7:0] regs;
		logic [7:0] rdata;
	} pdc_state_t;

	pdc_state_t st_reg;
	pdc_state_t st_next;
	logic second_output_float;

	function automatic logic reg_hit(input logic [7:0] addr);
		reg_hit = (addr >= pdc_pkg::OFS_REFDIV_OUT2_CONTROL)
			&& (addr <= pdc_pkg::OFS_LOOP_CONTROL_ZERO);
	endfunction

	function automatic logic [3:0] reg_index(input logic [7:0] addr);
		logic [7:0] diff;
		diff = addr - pdc_pkg::OFS_REFDIV_OUT2_CONTROL;
		reg_index = diff[3:0];
	endfunction

	////////////////////////////////////////////////////////////////////////
	// register file
	always_comb
	begin
		st_next = st_reg;
		if (reg_rd)
		begin
			// unmapped offsets answer zero
			if (reg_hit(reg_addr))
				st_next.rdata = st_reg.regs[reg_index(reg_addr)];
			else
				st_next.rdata = 8'h00;
		end
		if (reg_wr && reg_hit(reg_addr))
		begin
			// reserved bits masked at write so they always read back zero
			st_next.regs[reg_index(reg_addr)] =
				reg_wdata & pdc_pkg::WRITE_MASK[reg_index(reg_addr)];
		end
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			st_reg.regs <= pdc_pkg::RESET_IMAGE;
			st_reg.rdata <= 8'h00;
		end
		else
			st_reg <= st_next;
	end

	assign reg_rdata = st_reg.rdata;

	////////////////////////////////////////////////////////////////////////
	// field outputs
	// numerator goes straight out; glitch-free retune depends on write order
	assign second_output_float = st_reg.regs[pdc_pkg::IDX_CTL][pdc_pkg::BIT_OUT2_FLOAT];
	assign ref_predivide_sel =
		st_reg.regs[pdc_pkg::IDX_CTL][pdc_pkg::BIT_REF_PREDIVIDE];
	assign ref_doubler_en = st_reg.regs[pdc_pkg::IDX_PCTL][pdc_pkg::BIT_REF_DOUBLER];
	assign loop_integer_divisor = {st_reg.regs[pdc_pkg::IDX_NDIV_HI][3:0],
		st_reg.regs[pdc_pkg::IDX_NDIV_LO]};
	assign frac_numerator = {st_reg.regs[pdc_pkg::IDX_NUM2][5:0],
		st_reg.regs[pdc_pkg::IDX_NUM1], st_reg.regs[pdc_pkg::IDX_NUM0]};
	assign frac_denominator = {st_reg.regs[pdc_pkg::IDX_DEN2][5:0],
		st_reg.regs[pdc_pkg::IDX_DEN1], st_reg.regs[pdc_pkg::IDX_DEN0]};
	assign dither_select =
		st_reg.regs[pdc_pkg::IDX_MASH][pdc_pkg::POS_DITHER_SELECT +: 2];
	assign modulator_order = st_reg.regs[pdc_pkg::IDX_MASH][pdc_pkg::POS_ORDER +: 2];
	assign pump_current_code = st_reg.regs[pdc_pkg::IDX_PCTL][pdc_pkg::POS_PUMP_CODE +: 4];

	// reserved codes decode to none of the named settings
	assign dither_weak = (dither_select == pdc_pkg::DITHER_WEAK);
	assign dither_off = (dither_select == pdc_pkg::DITHER_OFF);
	assign order_integer = (modulator_order == pdc_pkg::ORDER_INTEGER);
	assign order_third = (modulator_order == pdc_pkg::ORDER_THIRD);
	assign pump_1p6_ma = (pump_current_code == pdc_pkg::PUMP_1P6_MA);
	assign pump_6p4_ma = (pump_current_code == pdc_pkg::PUMP_6P4_MA);

	pdc_out2_stage pdc_out2_stage_inst (
		.core_clk(core_clk),
		.nrst(nrst),
		.out2_src(out2_src),
		.second_output_float(second_output_float),
		.out2_level(out2_level),
		.out2_oe(out2_oe)
	);

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!nrst);

	AST_OUT2_FLOAT: assert property (
		reg_wr && reg_addr == pdc_pkg::OFS_REFDIV_OUT2_CONTROL
		|=> (out2_oe == !$past(reg_wdata[4])))
		else $error("output two enable does not follow float bit");

	AST_PREDIVIDE: assert property (
		reg_wr && reg_addr == pdc_pkg::OFS_REFDIV_OUT2_CONTROL
		|=> (ref_predivide_sel == $past(reg_wdata[0])))
		else $error("predivide select not taken from write");

	AST_DIVISOR_HIGH: assert property (
		reg_wr && reg_addr == pdc_pkg::OFS_LOOP_DIVISOR_HIGH
		|=> (loop_integer_divisor[11:8] == $past(reg_wdata[3:0]))
			&& $stable(loop_integer_divisor[7:0]))
		else $error("divisor upper nibble wrong");

	AST_DIVISOR_RESET: assert property (@(posedge core_clk) disable iff (1'b0)
		// second low edge: the first one is where the reset is still being applied
		!nrst ##1 !nrst |-> (loop_integer_divisor == 12'h032) && (frac_numerator == 22'h00_0000))
		else $error("divisor or numerator reset value wrong");

	AST_NUMERATOR: assert property (
		reg_wr && reg_addr == pdc_pkg::OFS_FRAC_NUMERATOR_BYTE2
		|=> (frac_numerator[21:16] == $past(reg_wdata[5:0])))
		else $error("numerator top bits wrong");

	AST_DENOMINATOR: assert property (
		reg_wr && reg_addr == pdc_pkg::OFS_FRAC_DENOMINATOR_BYTE0
		|=> (frac_denominator[7:0] == $past(reg_wdata)) ##1 $stable(frac_denominator) [*2])
		else $error("denominator low byte wrong or not held");

	AST_DITHER: assert property (
		reg_wr && reg_addr == pdc_pkg::OFS_MODULATOR_CONTROL && reg_wdata[3:2] == 2'h0
		|=> dither_weak && !dither_off)
		else $error("weak dither not selected");

	AST_ORDER: assert property (
		reg_wr && reg_addr == pdc_pkg::OFS_MODULATOR_CONTROL && reg_wdata[1:0] == 2'h3
		|=> order_third && !order_integer)
		else $error("third order not selected");

	AST_DOUBLER: assert property (
		reg_wr && reg_addr == pdc_pkg::OFS_LOOP_CONTROL_ZERO
		|=> (ref_doubler_en == $past(reg_wdata[5])))
		else $error("doubler enable not taken from write");

	AST_PUMP: assert property (
		reg_wr && reg_addr == pdc_pkg::OFS_LOOP_CONTROL_ZERO && reg_wdata[3:0] == 4'h4
		|=> pump_1p6_ma && !pump_6p4_ma)
		else $error("pump code four not decoded");

	AST_RESERVED: assert property (
		reg_rd && !reg_wr && reg_addr == pdc_pkg::OFS_MODULATOR_CONTROL
		|=> (reg_rdata[7:4] == 4'h0))
		else $error("reserved bits read nonzero");

	AST_DIVISOR_LOW: assert property (
		reg_wr && reg_addr == pdc_pkg::OFS_LOOP_DIVISOR_LOW
		|=> (loop_integer_divisor[7:0] == $past(reg_wdata))
			&& $stable(loop_integer_divisor[11:8]))
		else $error("divisor low byte wrong");

	AST_RESET_FIELDS: assert property (@(posedge core_clk) disable iff (1'b0)
		!nrst ##1 !nrst |-> ref_doubler_en && !ref_predivide_sel && !out2_oe
			&& dither_off && order_integer && pump_6p4_ma
			&& (frac_denominator == 22'h00_0000))
		else $error("control field reset value wrong");

	AST_UNMAPPED_READ: assert property (
		reg_rd && !reg_hit(reg_addr)
		|=> (reg_rdata == 8'h00))
		else $error("unmapped offset read nonzero");

	// reset clears the chain, so only judge once three clean edges have passed
	AST_OUT2_FOLLOWS: assert property (
		$past(nrst) && $past(nrst, 2) && $past(nrst, 3) && !second_output_float
		|-> (out2_level == $past(out2_src, 3)))
		else $error("output two does not follow its source");

	AST_PUMP_HIGH: assert property (
		reg_wr && reg_addr == pdc_pkg::OFS_LOOP_CONTROL_ZERO && reg_wdata[3:0] == 4'h8
		|=> pump_6p4_ma && !pump_1p6_ma)
		else $error("pump code eight not decoded");

	AST_DITHER_OFF: assert property (
		reg_wr && reg_addr == pdc_pkg::OFS_MODULATOR_CONTROL && reg_wdata[3:2] == 2'h3
		|=> dither_off && !dither_weak)
		else $error("dither not disabled");

	AST_ORDER_INTEGER: assert property (
		reg_wr && reg_addr == pdc_pkg::OFS_MODULATOR_CONTROL && reg_wdata[1:0] == 2'h0
		|=> order_integer && !order_third)
		else $error("integer mode not selected");

endmodule

// *** core/pdc_out2_stage.sv ***
`timescale 1ns/1ns
module pdc_out2_stage (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic out2_src,
	input wire logic second_output_float,
	output logic out2_level,
	output logic out2_oe
);

	typedef struct packed {
		logic sync1;
		logic sync2;
		logic drive;
	} pdc_out2_state_t;

	pdc_out2_state_t st_reg;
	pdc_out2_state_t st_next;

	////////////////////////////////////////////////////////////////////////
	// source arrives from the synthesizer domain, so two stages first
	always_comb
	begin
		st_next = st_reg;
		st_next.sync1 = out2_src;
		st_next.sync2 = st_reg.sync1;
		st_next.drive = st_reg.sync2;
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign out2_level = st_reg.drive;
	// floating the pin releases the enable; level stays but nobody drives
	assign out2_oe = !second_output_float;

endmodule

// *** core/pdc_pkg.sv ***
package pdc_pkg;

	localparam int NUM_REGS = 11;

	// byte offsets on the register port
	localparam logic [7:0] OFS_REFDIV_OUT2_CONTROL = 8'h18;
	localparam logic [7:0] OFS_LOOP_DIVISOR_HIGH = 8'h19;
	localparam logic [7:0] OFS_LOOP_DIVISOR_LOW = 8'h1a;
	localparam logic [7:0] OFS_FRAC_NUMERATOR_BYTE2 = 8'h1b;
	localparam logic [7:0] OFS_FRAC_NUMERATOR_BYTE1 = 8'h1c;
	localparam logic [7:0] OFS_FRAC_NUMERATOR_BYTE0 = 8'h1d;
	localparam logic [7:0] OFS_FRAC_DENOMINATOR_BYTE2 = 8'h1e;
	localparam logic [7:0] OFS_FRAC_DENOMINATOR_BYTE1 = 8'h1f;
	localparam logic [7:0] OFS_FRAC_DENOMINATOR_BYTE0 = 8'h20;
	localparam logic [7:0] OFS_MODULATOR_CONTROL = 8'h21;
	localparam logic [7:0] OFS_LOOP_CONTROL_ZERO = 8'h22;

	// storage index of each register
	localparam int IDX_CTL = 0;
	localparam int IDX_NDIV_HI = 1;
	localparam int IDX_NDIV_LO = 2;
	localparam int IDX_NUM2 = 3;
	localparam int IDX_NUM1 = 4;
	localparam int IDX_NUM0 = 5;
	localparam int IDX_DEN2 = 6;
	localparam int IDX_DEN1 = 7;
	localparam int IDX_DEN0 = 8;
	localparam int IDX_MASH = 9;
	localparam int IDX_PCTL = 10;

	// field positions
	localparam int BIT_OUT2_FLOAT = 4;
	localparam int BIT_REF_PREDIVIDE = 0;
	localparam int BIT_REF_DOUBLER = 5;
	localparam int POS_DITHER_SELECT = 2;
	localparam int POS_ORDER = 0;
	localparam int POS_PUMP_CODE = 0;

	// reset values
	localparam logic [7:0] RST_CTL = 8'h10;
	localparam logic [7:0] RST_NDIV_HI = 8'h00;
	localparam logic [7:0] RST_NDIV_LO = 8'h32;
	localparam logic [7:0] RST_FRAC = 8'h00;
	localparam logic [7:0] RST_MASH = 8'h0c;
	localparam logic [7:0] RST_PCTL = 8'h28;

	// writable bits; everything else is reserved and reads zero
	localparam logic [7:0] WM_CTL = 8'h11;
	localparam logic [7:0] WM_NIBBLE = 8'h0f;
	localparam logic [7:0] WM_BYTE = 8'hff;
	localparam logic [7:0] WM_SIX = 8'h3f;
	localparam logic [7:0] WM_PCTL = 8'hef;

	localparam logic [10:0][7:0] RESET_IMAGE = {RST_PCTL, RST_MASH, RST_FRAC, RST_FRAC,
		RST_FRAC, RST_FRAC, RST_FRAC, RST_FRAC, RST_NDIV_LO, RST_NDIV_HI, RST_CTL};
	localparam logic [10:0][7:0] WRITE_MASK = {WM_PCTL, WM_NIBBLE, WM_BYTE, WM_BYTE,
		WM_SIX, WM_BYTE, WM_BYTE, WM_SIX, WM_BYTE, WM_NIBBLE, WM_CTL};

	// field encodings
	localparam logic [1:0] DITHER_WEAK = 2'h0;
	localparam logic [1:0] DITHER_OFF = 2'h3;
	localparam logic [1:0] ORDER_INTEGER = 2'h0;
	localparam logic [1:0] ORDER_THIRD = 2'h3;
	localparam logic [3:0] PUMP_1P6_MA = 4'h4;
	localparam logic [3:0] PUMP_6P4_MA = 4'h8;

endpackage

// *** dv/test_pdc_config_regs.sv ***
`timescale 1ns/1ns
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin error_cnt++; \
	$display("wrong value at %0t got %h exp %h", $time, (got), (exp)); end end
module test_pdc_config_regs;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic reg_wr = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic out2_src = 1'b0;
	logic out2_level, out2_oe, ref_predivide_sel, ref_doubler_en;
	logic [11:0] loop_integer_divisor;
	logic [21:0] frac_numerator, frac_denominator;
	logic [1:0] dither_select, modulator_order;
	logic dither_weak, dither_off, order_integer, order_third;
	logic [3:0] pump_current_code;
	logic pump_1p6_ma, pump_6p4_ma;
	int error_cnt = 0;
	int total_checks = 0;
	int i;
	pdc_config_regs pdc_config_regs_inst (.core_clk(core_clk), .nrst(nrst),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .out2_src(out2_src), .out2_level(out2_level),
		.out2_oe(out2_oe),
		.ref_predivide_sel(ref_predivide_sel), .ref_doubler_en(ref_doubler_en),
		.loop_integer_divisor(loop_integer_divisor), .frac_numerator(frac_numerator),
		.frac_denominator(frac_denominator), .dither_select(dither_select),
		.dither_weak(dither_weak), .dither_off(dither_off),
		.modulator_order(modulator_order), .order_integer(order_integer),
		.order_third(order_third), .pump_current_code(pump_current_code),
		.pump_1p6_ma(pump_1p6_ma), .pump_6p4_ma(pump_6p4_ma));
	initial
	begin
		forever #10 core_clk = ~core_clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	// both tasks start and end at a falling edge; an idle cycle follows each
	// strobe so the next call never re-raises it in the same step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
		@(negedge core_clk);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge core_clk);
		reg_rd = 1'b0;
		`CHK(reg_rdata, e)
		@(negedge core_clk);
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// watchdog: the whole sequence needs well under this many cycles
	initial
	begin
		repeat (5000) @(posedge core_clk);
		error_cnt++;
		close_out;
	end
	initial
	begin
		repeat (3) @(negedge core_clk);
		nrst = 1'b1;
		`CHK(out2_oe, 1'b0)
		`CHK(ref_predivide_sel, 1'b0)
		`CHK(loop_integer_divisor, 12'h032)
		`CHK({frac_numerator, frac_denominator}, 44'h000_0000_0000)
		`CHK({dither_off, order_integer, ref_doubler_en, pump_6p4_ma}, 4'hf)
		rdc(8'h18, 8'h10);
		rdc(8'h19, 8'h00);
		rdc(8'h1a, 8'h32);
		for (i = 3; i < 9; i++)
			rdc(8'h18 + i[7:0], 8'h00);
		rdc(8'h21, 8'h0c);
		rdc(8'h22, 8'h28);
		$display("test reset values done");
		// all ones everywhere shows which bits are reserved
		for (i = 0; i < 11; i++)
			wr(8'h18 + i[7:0], 8'hff);
		wr(8'h23, 8'hff);
		wr(8'h17, 8'hff);
		rdc(8'h18, 8'h11);
		rdc(8'h19, 8'h0f);
		rdc(8'h1b, 8'h3f);
		rdc(8'h1e, 8'h3f);
		rdc(8'h21, 8'h0f);
		rdc(8'h22, 8'hef);
		rdc(8'h23, 8'h00);
		rdc(8'h17, 8'h00);
		`CHK(loop_integer_divisor, 12'hfff)
		`CHK({frac_numerator, frac_denominator}, 44'hfff_ffff_ffff)
		`CHK({out2_oe, ref_predivide_sel, ref_doubler_en}, 3'b011)
		wr(8'h18, 8'h00);
		`CHK({out2_oe, ref_predivide_sel}, 2'b10)
		$display("test masks done");
		for (i = 0; i < 4; i++)
		begin
			wr(8'h21, {4'h0, i[1:0], i[1:0]});
			`CHK(dither_select, i[1:0])
			`CHK({dither_weak, dither_off}, {i == 0, i == 3})
			`CHK(modulator_order, i[1:0])
			`CHK({order_integer, order_third}, {i == 0, i == 3})
		end
		for (i = 0; i < 16; i++)
		begin
			wr(8'h22, {4'h0, i[3:0]});
			`CHK(pump_current_code, i[3:0])
			`CHK({pump_1p6_ma, pump_6p4_ma}, {i == 4, i == 8})
			`CHK(ref_doubler_en, 1'b0)
		end
		$display("test codes done");
		// retune the way a host should: most significant byte first
		wr(8'h1b, 8'h2a);
		`CHK(frac_numerator[21:16], 6'h2a)
		wr(8'h1c, 8'h5c);
		wr(8'h1d, 8'h93);
		`CHK(frac_numerator, 22'h2a_5c93)
		wr(8'h1e, 8'hc1);
		wr(8'h1f, 8'h02);
		wr(8'h20, 8'h03);
		`CHK(frac_denominator, 22'h01_0203)
		wr(8'h19, 8'ha5);
		wr(8'h1a, 8'h3c);
		`CHK(loop_integer_divisor, 12'h53c)
		$display("test divisors done");
		out2_src = 1'b1;
		repeat (2) @(negedge core_clk);
		`CHK(out2_level, 1'b0)
		@(negedge core_clk);
		`CHK(out2_level, 1'b1)
		wr(8'h18, 8'h10);
		`CHK(out2_oe, 1'b0)
		$display("test output two done");
		// a reset in mid-run must bring back the startup image
		nrst = 1'b0;
		repeat (2) @(negedge core_clk);
		`CHK({out2_oe, out2_level, reg_rdata}, 10'h000)
		`CHK(loop_integer_divisor, 12'h032)
		nrst = 1'b1;
		rdc(8'h20, 8'h00);
		rdc(8'h1a, 8'h32);
		`CHK(frac_numerator, 22'h00_0000)
		$display("test second reset done");
		close_out;
	end
endmodule
